// ### hdl/ddrioe_pkg.sv
// Constants shared by the DDR-capable I/O element
package ddrioe_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register bus
    localparam int AW = 4;
    localparam int DW = 32;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_SEL = 4'h4;
    localparam logic [3:0] OFS_INV = 4'h8;
    localparam logic [3:0] OFS_STAT = 4'hC;

    ////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int CTRL_MODE = 0;
    localparam int CTRL_PRESET = 2;
    localparam int CTRL_OE_LOW = 3;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [1:0] MODE_SDR = 2'h0;
    localparam logic [1:0] MODE_DDR_IN = 2'h1;
    localparam logic [1:0] MODE_DDR_OUT = 2'h2;
    localparam logic [1:0] MODE_DDR_BI = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Source select fields, four bits each
    localparam int SEL_W = 4;
    localparam int SEL_CLK_IN = 0;
    localparam int SEL_CLK_OUT = 4;
    localparam int SEL_CE_IN = 8;
    localparam int SEL_CE_OUT = 12;
    localparam int SEL_OE = 16;
    localparam int SEL_ACLR = 20;
    localparam int SEL_SCLR = 24;
    localparam logic [31:0] SEL_RST = 32'h0FFF_FF00;

    ////////////////////////////////////////////////////////////////////////
    // Inversion mask bits
    localparam int INV_W = 10;
    localparam int INV_DA = 0;
    localparam int INV_DB = 1;
    localparam int INV_OE = 2;
    localparam int INV_CE_IN = 3;
    localparam int INV_CE_OUT = 4;
    localparam int INV_CLK_IN = 5;
    localparam int INV_CLK_OUT = 6;
    localparam int INV_ACLR = 7;
    localparam int INV_SCLR = 8;
    localparam int INV_PIN = 9;
    localparam logic [9:0] INV_RST = 10'h000;

    ////////////////////////////////////////////////////////////////////////
    // Block bundle and capacity
    localparam int BUNDLE_W = 4;
    localparam int IOCLK_W = 8;
    localparam logic [3:0] ROW_ELEMS = 4'h4;
    localparam logic [3:0] COL_ELEMS = 4'h6;

endpackage

// ### hdl/ddrioe_top.sv
// DDR-capable I/O element: one pin, six registers and a latch
`timescale 1ns/100ps

// Contract
// - Two input registers plus latch, two output and two enable registers
// - DDR input: one register captures on rising, one on falling edge
// - Latch keeps high-phase bit so both bits align to one edge
// - DDR output: both output registers load fabric data on rising edge
// - Pin shows first bit while clock high, second while clock low
// - Bidirectional DDR: enable passes a falling-edge register before pin
// - Bidirectional DDR combines DDR capture and DDR drive on one pin
// - Input registers have own clock and clock enable
// - Output and enable registers share one clock and one enable
// - Element selects its enable, clock enables, clears and clocks
// - One clear source for all registers, acting as clear or preset
// - Registers come up high or low once configured
// - Low start uses async clear, high start uses async preset
// - Registers also take a synchronous reset
// - Every input into the element can be inverted
// - Driver enable active high by default, active low optional
// - Block bundle: four enables, clock enables, clocks, clears
// - Row block holds four elements, column block six
// - Eight low-skew element clocks available as register clocks
module ddrioe_top #(
    parameter bit IS_COLUMN = 1'b0,
    parameter logic [2:0] ELEM_POS = 3'h0
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [3:0] blk_oe,
    input wire logic [3:0] blk_ce,
    input wire logic [3:0] blk_clk,
    input wire logic [3:0] blk_clr,
    input wire logic [7:0] io_clk,
    input wire logic loc_oe,
    input wire logic loc_ce_in,
    input wire logic loc_ce_out,
    input wire logic loc_clk,
    input wire logic loc_aclr,
    input wire logic loc_sclr,
    input wire logic fab_dout_a,
    input wire logic fab_dout_b,
    output logic fab_din_sdr,
    output logic fab_din_hi,
    output logic fab_din_lo,
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [31:0] ctrl_r;
    logic [31:0] sel_r;
    logic [9:0] inv_r;
    logic [31:0] rdata_r;
    logic [31:0] rd_nxt;
    logic cap_pos_r;
    logic cap_neg_r;
    logic cap_lat_r;
    logic out_a_r;
    logic out_b_r;
    logic oe_pos_r;
    logic oe_neg_r;
    logic pin_o_r;
    logic pin_oe_r;
    logic clk_in_q_r;
    logic clk_out_q_r;
    logic clk_in_lvl;
    logic clk_out_lvl;
    logic ce_in_on;
    logic ce_out_on;
    logic oe_sel;
    logic aclr_on;
    logic sclr_on;
    logic d_a;
    logic d_b;
    logic pin_lvl;
    logic rise_in;
    logic fall_in;
    logic rise_out;
    logic fall_out;
    logic ddr_in;
    logic ddr_out;
    logic mode_bi;
    logic iv;
    logic iv_load;
    logic ctrl_wr;
    logic oe_eff;
    logic drive_nxt;
    logic [1:0] mode;
    logic [3:0] cap;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic pick(input logic [15:0] v,
                                  input logic [3:0] s);
        pick = v[s];
    endfunction

    // Register step: sync reset wins over data on an enabled edge
    function automatic logic upd(input logic cur, input logic d,
                                 input logic edg, input logic ce,
                                 input logic sc, input logic ivv);
        if (edg && ce) begin
            upd = sc ? ivv : d;
        end else begin
            upd = cur;
        end
    endfunction

    function automatic logic [3:0] fld(input logic [31:0] r,
                                       input int lsb);
        fld = r[lsb +: 4];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Source selection and inversion
    assign clk_in_lvl = pick({3'h0, loc_clk, io_clk, blk_clk},
        fld(sel_r, ddrioe_pkg::SEL_CLK_IN))
        ^ inv_r[ddrioe_pkg::INV_CLK_IN];
    assign clk_out_lvl = pick({3'h0, loc_clk, io_clk, blk_clk},
        fld(sel_r, ddrioe_pkg::SEL_CLK_OUT))
        ^ inv_r[ddrioe_pkg::INV_CLK_OUT];
    assign ce_in_on = pick({1'b1, 10'h000, loc_ce_in, blk_ce},
        fld(sel_r, ddrioe_pkg::SEL_CE_IN))
        ^ inv_r[ddrioe_pkg::INV_CE_IN];
    assign ce_out_on = pick({1'b1, 10'h000, loc_ce_out, blk_ce},
        fld(sel_r, ddrioe_pkg::SEL_CE_OUT))
        ^ inv_r[ddrioe_pkg::INV_CE_OUT];
    assign oe_sel = pick({1'b1, 10'h000, loc_oe, blk_oe},
        fld(sel_r, ddrioe_pkg::SEL_OE))
        ^ inv_r[ddrioe_pkg::INV_OE];
    assign aclr_on = pick({11'h000, loc_aclr, blk_clr},
        fld(sel_r, ddrioe_pkg::SEL_ACLR))
        ^ inv_r[ddrioe_pkg::INV_ACLR];
    assign sclr_on = pick({11'h000, loc_sclr, blk_clr},
        fld(sel_r, ddrioe_pkg::SEL_SCLR))
        ^ inv_r[ddrioe_pkg::INV_SCLR];
    assign d_a = fab_dout_a ^ inv_r[ddrioe_pkg::INV_DA];
    assign d_b = fab_dout_b ^ inv_r[ddrioe_pkg::INV_DB];
    assign pin_lvl = pin_i ^ inv_r[ddrioe_pkg::INV_PIN];

    assign mode = ctrl_r[ddrioe_pkg::CTRL_MODE +: 2];
    assign mode_bi = (mode == ddrioe_pkg::MODE_DDR_BI);
    assign ddr_in = (mode == ddrioe_pkg::MODE_DDR_IN) || mode_bi;
    assign ddr_out = (mode == ddrioe_pkg::MODE_DDR_OUT) || mode_bi;
    assign iv = ctrl_r[ddrioe_pkg::CTRL_PRESET];
    assign ctrl_wr = reg_wr && (reg_addr == ddrioe_pkg::OFS_CTRL);
    assign iv_load = ctrl_wr ? reg_wdata[ddrioe_pkg::CTRL_PRESET] : iv;

    ////////////////////////////////////////////////////////////////////////
    // Element clock edge detection
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            clk_in_q_r <= 1'b0;
            clk_out_q_r <= 1'b0;
        end else if (clk_en) begin
            clk_in_q_r <= clk_in_lvl;
            clk_out_q_r <= clk_out_lvl;
        end
    end

    assign rise_in = clk_in_lvl && !clk_in_q_r;
    assign fall_in = !clk_in_lvl && clk_in_q_r;
    assign rise_out = clk_out_lvl && !clk_out_q_r;
    assign fall_out = !clk_out_lvl && clk_out_q_r;

    ////////////////////////////////////////////////////////////////////////
    // Register bus
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= ddrioe_pkg::CTRL_RST;
            sel_r <= ddrioe_pkg::SEL_RST;
            inv_r <= ddrioe_pkg::INV_RST;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == ddrioe_pkg::OFS_CTRL) begin
                ctrl_r <= {28'h0000000, reg_wdata[3:0]};
            end
            if (reg_addr == ddrioe_pkg::OFS_SEL) begin
                sel_r <= {4'h0, reg_wdata[27:0]};
            end
            if (reg_addr == ddrioe_pkg::OFS_INV) begin
                inv_r <= reg_wdata[ddrioe_pkg::INV_W-1:0];
            end
        end
    end

    // Capacity of the enclosing block
    assign cap = IS_COLUMN ? ddrioe_pkg::COL_ELEMS
                           : ddrioe_pkg::ROW_ELEMS;

    always_comb begin
        unique case (reg_addr)
            ddrioe_pkg::OFS_CTRL: rd_nxt = ctrl_r;
            ddrioe_pkg::OFS_SEL: rd_nxt = sel_r;
            ddrioe_pkg::OFS_INV: rd_nxt = {22'h000000, inv_r};
            ddrioe_pkg::OFS_STAT: begin
                rd_nxt = {12'h000, cap, 1'b0, ELEM_POS, 2'h0, pin_oe_r,
                          pin_o_r, oe_neg_r, oe_pos_r, out_b_r, out_a_r,
                          cap_neg_r, cap_lat_r, cap_pos_r, clk_in_lvl};
            end
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 32'h0000_0000;
        end else if (clk_en) begin
            rdata_r <= reg_rd ? rd_nxt : 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_r;

    property p_rd_sel;
        clk_en && reg_rd && reg_addr == ddrioe_pkg::OFS_SEL
        |=> reg_rdata == $past(sel_r);
    endproperty
    a_rd_sel: assert property (p_rd_sel)
        else $error("select read back wrong");
    property p_cap;
        clk_en && reg_rd && reg_addr == ddrioe_pkg::OFS_STAT
        |=> reg_rdata[19:16] == (IS_COLUMN ? 4'h6 : 4'h4);
    endproperty
    a_cap: assert property (p_cap)
        else $error("block capacity wrong");

    ////////////////////////////////////////////////////////////////////////
    // Input path: rising register, falling register, latch
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cap_pos_r <= 1'b0;
            cap_neg_r <= 1'b0;
            cap_lat_r <= 1'b0;
        end else if (clk_en) begin
            if (aclr_on || ctrl_wr) begin
                cap_pos_r <= iv_load;
                cap_neg_r <= iv_load;
                cap_lat_r <= iv_load;
            end else begin
                cap_pos_r <= upd(cap_pos_r, pin_lvl, rise_in, ce_in_on,
                                 sclr_on, iv);
                cap_neg_r <= upd(cap_neg_r, pin_lvl, fall_in && ddr_in,
                                 ce_in_on, sclr_on, iv);
                cap_lat_r <= upd(cap_lat_r, cap_pos_r, fall_in && ddr_in,
                                 ce_in_on, sclr_on, iv);
            end
        end
    end

    assign fab_din_sdr = cap_pos_r;
    assign fab_din_hi = cap_lat_r;
    assign fab_din_lo = cap_neg_r;

    property p_in_rise;
        clk_en && rise_in && ce_in_on && !aclr_on && !sclr_on && !ctrl_wr
        |=> cap_pos_r == $past(pin_lvl);
    endproperty
    a_in_rise: assert property (p_in_rise)
        else $error("rising capture missed");

    property p_in_fall;
        clk_en && fall_in && ddr_in && ce_in_on && !aclr_on && !sclr_on
        && !ctrl_wr |=> cap_neg_r == $past(pin_lvl) && cap_lat_r ==
        $past(cap_pos_r);
    endproperty
    a_in_fall: assert property (p_in_fall)
        else $error("falling capture or latch wrong");

    property p_in_hold;
        clk_en && !rise_in && !aclr_on && !ctrl_wr |=> $stable(cap_pos_r);
    endproperty
    a_in_hold: assert property (p_in_hold)
        else $error("input register moved off its edge");

    ////////////////////////////////////////////////////////////////////////
    // Output path: two data registers and two enable registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            out_a_r <= 1'b0;
            out_b_r <= 1'b0;
            oe_pos_r <= 1'b0;
            oe_neg_r <= 1'b0;
        end else if (clk_en) begin
            if (aclr_on || ctrl_wr) begin
                out_a_r <= iv_load;
                out_b_r <= iv_load;
                oe_pos_r <= iv_load;
                oe_neg_r <= iv_load;
            end else begin
                out_a_r <= upd(out_a_r, d_a, rise_out, ce_out_on,
                               sclr_on, iv);
                out_b_r <= upd(out_b_r, d_b, rise_out && ddr_out,
                               ce_out_on, sclr_on, iv);
                oe_pos_r <= upd(oe_pos_r, oe_sel, rise_out, ce_out_on,
                                sclr_on, iv);
                oe_neg_r <= upd(oe_neg_r, oe_pos_r, fall_out, ce_out_on,
                                sclr_on, iv);
            end
        end
    end

    property p_out_load;
        clk_en && rise_out && ddr_out && ce_out_on && !aclr_on && !sclr_on
        && !ctrl_wr |=> out_a_r == $past(d_a) && out_b_r == $past(d_b);
    endproperty
    a_out_load: assert property (p_out_load)
        else $error("output registers did not load");

    property p_sclr;
        clk_en && rise_out && ce_out_on && sclr_on && !aclr_on && !ctrl_wr
        |=> out_a_r == $past(iv) && oe_pos_r == $past(iv);
    endproperty
    a_sclr: assert property (p_sclr)
        else $error("sync reset not applied");

    property p_aclr;
        clk_en && aclr_on && !ctrl_wr
        |=> cap_pos_r == $past(iv) && out_a_r == $past(iv)
        && oe_neg_r == $past(iv) && cap_lat_r == $past(iv);
    endproperty
    a_aclr: assert property (p_aclr)
        else $error("async clear or preset not forced");

    property p_oe_neg;
        clk_en && !fall_out && !aclr_on && !ctrl_wr |=> $stable(oe_neg_r);
    endproperty
    a_oe_neg: assert property (p_oe_neg)
        else $error("falling enable register moved off edge");

    property p_cfg_init;
        clk_en && ctrl_wr
        |=> out_b_r == ctrl_r[2] && cap_neg_r == ctrl_r[2];
    endproperty
    a_cfg_init: assert property (p_cfg_init)
        else $error("registers did not take start value");

    ////////////////////////////////////////////////////////////////////////
    // Pin driver
    assign oe_eff = mode_bi ? oe_neg_r : oe_pos_r;
    assign drive_nxt = (mode == ddrioe_pkg::MODE_DDR_IN) ? 1'b0
        : (oe_eff ^ ctrl_r[ddrioe_pkg::CTRL_OE_LOW]);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_o_r <= 1'b0;
            pin_oe_r <= 1'b0;
        end else if (clk_en) begin
            pin_o_r <= (ddr_out && !clk_out_lvl) ? out_b_r
                                                 : out_a_r;
            pin_oe_r <= drive_nxt;
        end
    end

    assign pin_o = pin_o_r;
    assign pin_oe = pin_oe_r;

    property p_pin_mux;
        clk_en && ddr_out |=> pin_o_r ==
        ($past(clk_out_lvl) ? $past(out_a_r) : $past(out_b_r));
    endproperty
    a_pin_mux: assert property (p_pin_mux)
        else $error("pin shows wrong half bit");

    property p_pin_oe;
        clk_en && mode_bi |=> pin_oe_r ==
        ($past(oe_neg_r) ^ $past(ctrl_r[3]));
    endproperty
    a_pin_oe: assert property (p_pin_oe)
        else $error("driver enable not from falling register");

    property p_freeze;
        !clk_en |=> $stable(out_a_r) && $stable(pin_o_r)
        && $stable(cap_pos_r) && $stable(ctrl_r);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");

endmodule

// ### verification/ddrioe_mem_model.sv
// Far-side DDR device model on the element pin
`timescale 1ns/100ps
module ddrioe_mem_model (
    input wire logic sys_clk,
    input wire logic eclk,
    input wire logic drv_en,
    input wire logic d_hi,
    input wire logic d_lo,
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic pin_i
);
    logic float_r = 1'h0;

    ////////////////////////////////////////////////////////////////////////
    // Undriven pin has no pull, so it wanders
    always_ff @(posedge sys_clk) begin
        float_r <= ~pin_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // Wire level from both parties
    always_comb begin
        if (pin_oe) begin
            pin_i = pin_o;
        end else if (drv_en) begin
            pin_i = eclk ? d_hi : d_lo;
        end else begin
            pin_i = float_r;
        end
    end
endmodule

// ### verification/ddrioe_top_test.sv
// Self-checking bench for the DDR-capable I/O element
`timescale 1ns/100ps
module ddrioe_top_test;
    logic sys_clk = 1'h0;
    logic resetn = 1'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [31:0] reg_rdata;
    logic [3:0] blk_oe = 4'h0;
    logic [3:0] blk_ce = 4'h0;
    logic [3:0] blk_clr = 4'h0;
    logic [3:0] blk_clk;
    logic [7:0] io_clk;
    logic loc_ce_in = 1'h0;
    logic loc_ce_out = 1'h0;
    logic clk_en = 1'h1;
    logic loc_aclr = 1'h0;
    logic eclk = 1'h0;
    logic use_io = 1'h0;
    logic drv_en = 1'h0;
    logic d_hi = 1'h0;
    logic d_lo = 1'h0;
    logic fab_dout_a = 1'h0;
    logic fab_dout_b = 1'h0;
    logic fab_din_sdr;
    logic fab_din_hi;
    logic fab_din_lo;
    logic pin_i;
    logic pin_o;
    logic pin_oe;
    logic [31:0] rv;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;

    assign blk_clk = {3'h0, eclk & ~use_io};
    assign io_clk = {4'h0, eclk & use_io, 3'h0};

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    ddrioe_top #(.IS_COLUMN(1'h0), .ELEM_POS(3'h5)) u_dut (
        .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .blk_oe(blk_oe), .blk_ce(blk_ce), .blk_clk(blk_clk),
        .blk_clr(blk_clr), .io_clk(io_clk), .loc_oe(1'h0),
        .loc_ce_in(loc_ce_in), .loc_ce_out(loc_ce_out), .loc_clk(1'h0),
        .loc_aclr(loc_aclr), .loc_sclr(1'h0),
        .fab_dout_a(fab_dout_a), .fab_dout_b(fab_dout_b),
        .fab_din_sdr(fab_din_sdr), .fab_din_hi(fab_din_hi),
        .fab_din_lo(fab_din_lo), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe(pin_oe)
    );

    ddrioe_mem_model u_mem (
        .sys_clk(sys_clk), .eclk(eclk), .drv_en(drv_en), .d_hi(d_hi),
        .d_lo(d_lo), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i)
    );

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        #1;
        d = reg_rdata;
    endtask

    task automatic half(input logic lvl);
        @(posedge sys_clk);
        eclk <= lvl;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic cyc(input logic h, input logic l);
        @(posedge sys_clk);
        d_hi <= h;
        d_lo <= l;
        half(1'h1);
        half(1'h0);
    endtask

    task automatic inx(input logic h, input logic l);
        chk("din_hi", fab_din_hi, h);
        chk("din_lo", fab_din_lo, l);
    endtask

    task automatic hold_clr(input logic [3:0] v);
        @(posedge sys_clk);
        blk_clr <= v;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic outx(input logic a, input logic b, input logic ea,
                        input logic eb);
        @(posedge sys_clk);
        fab_dout_a <= a;
        fab_dout_b <= b;
        half(1'h1);
        chk("pin_o high", pin_o, ea);
        half(1'h0);
        chk("pin_o low", pin_o, eb);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'h1;
        rd(ddrioe_pkg::OFS_CTRL, rv);
        chk("ctrl", rv, ddrioe_pkg::CTRL_RST);
        @(posedge sys_clk);
        #1;
        chk("rdata idle", reg_rdata, 32'h0);
        rd(ddrioe_pkg::OFS_SEL, rv);
        chk("sel", rv, ddrioe_pkg::SEL_RST);
        rd(ddrioe_pkg::OFS_STAT, rv);
        chk("status", rv & 32'h000F_7000, 32'h0004_5000);
        wr(4'h2, 32'hFFFF_FFFF);
        rd(4'h2, rv);
        chk("unmapped", rv, 32'h0);
        rd(ddrioe_pkg::OFS_INV, rv);
        chk("inv", rv, 32'h0);
        // DDR capture of every bit pair
        wr(ddrioe_pkg::OFS_CTRL, 32'h1);
        drv_en <= 1'h1;
        for (int k = 0; k < 4; k++) begin
            cyc(k[1], k[0]);
            inx(k[1], k[0]);
            chk("sdr", fab_din_sdr, k[1]);
        end
        chk("oe ddr in", pin_oe, 1'h0);
        // Clock enable low freezes the element
        @(posedge sys_clk);
        clk_en <= 1'h0;
        cyc(1'h0, 1'h0);
        inx(1'h1, 1'h1);
        @(posedge sys_clk);
        clk_en <= 1'h1;
        // Pin inversion
        wr(ddrioe_pkg::OFS_INV, 32'h200);
        cyc(1'h1, 1'h0);
        inx(1'h0, 1'h1);
        wr(ddrioe_pkg::OFS_INV, 32'h0);
        // Input enable from local routing
        wr(ddrioe_pkg::OFS_SEL, 32'h0FFF_F400);
        cyc(1'h1, 1'h0);
        inx(1'h0, 1'h1);
        @(posedge sys_clk);
        loc_ce_in <= 1'h1;
        cyc(1'h1, 1'h0);
        inx(1'h1, 1'h0);
        // Dedicated element clock
        wr(ddrioe_pkg::OFS_SEL, 32'h0FFF_FF07);
        use_io <= 1'h1;
        cyc(1'h0, 1'h1);
        inx(1'h0, 1'h1);
        use_io <= 1'h0;
        // Async clear and preset with element clock stopped
        wr(ddrioe_pkg::OFS_SEL, 32'h0F1F_FF00);
        cyc(1'h1, 1'h1);
        hold_clr(4'h2);
        inx(1'h0, 1'h0);
        hold_clr(4'h0);
        wr(ddrioe_pkg::OFS_CTRL, 32'h5);
        repeat (2) @(posedge sys_clk);
        #1;
        inx(1'h1, 1'h1);
        cyc(1'h0, 1'h0);
        hold_clr(4'h2);
        inx(1'h1, 1'h1);
        hold_clr(4'h0);
        // Clear source from local routing
        wr(ddrioe_pkg::OFS_SEL, 32'h0F4F_FF00);
        cyc(1'h0, 1'h0);
        @(posedge sys_clk);
        loc_aclr <= 1'h1;
        repeat (3) @(posedge sys_clk);
        #1;
        inx(1'h1, 1'h1);
        @(posedge sys_clk);
        loc_aclr <= 1'h0;
        // Synchronous reset
        wr(ddrioe_pkg::OFS_CTRL, 32'h1);
        wr(ddrioe_pkg::OFS_SEL, 32'h021F_FF00);
        hold_clr(4'h4);
        cyc(1'h1, 1'h1);
        inx(1'h0, 1'h0);
        hold_clr(4'h0);
        cyc(1'h1, 1'h1);
        inx(1'h1, 1'h1);
        // Single-rate drive, then DDR drive
        wr(ddrioe_pkg::OFS_SEL, ddrioe_pkg::SEL_RST);
        wr(ddrioe_pkg::OFS_CTRL, 32'h0);
        outx(1'h1, 1'h0, 1'h1, 1'h1);
        wr(ddrioe_pkg::OFS_CTRL, 32'h2);
        for (int k = 0; k < 4; k++) begin
            outx(k[1], k[0], k[1], k[0]);
        end
        chk("oe high", pin_oe, 1'h1);
        wr(ddrioe_pkg::OFS_SEL, 32'h0FFF_4F00);
        outx(1'h0, 1'h0, 1'h1, 1'h1);
        @(posedge sys_clk);
        loc_ce_out <= 1'h1;
        outx(1'h0, 1'h1, 1'h0, 1'h1);
        wr(ddrioe_pkg::OFS_CTRL, 32'hA);
        outx(1'h1, 1'h0, 1'h1, 1'h0);
        chk("oe low", pin_oe, 1'h0);
        // Bidirectional DDR
        wr(ddrioe_pkg::OFS_SEL, 32'h0FF0_FF00);
        wr(ddrioe_pkg::OFS_CTRL, 32'h3);
        drv_en <= 1'h1;
        cyc(1'h1, 1'h0);
        inx(1'h1, 1'h0);
        chk("oe idle", pin_oe, 1'h0);
        @(posedge sys_clk);
        blk_oe <= 4'h1;
        drv_en <= 1'h0;
        half(1'h1);
        chk("oe rise", pin_oe, 1'h0);
        half(1'h0);
        chk("oe fall", pin_oe, 1'h1);
        test_done();
    end
endmodule
